// File: src/dcdac_regs.sv
// serial slave and two current setting registers of the dual current dac
// Operation
// R1 - two 8-bit settings, F8h drives output zero, F9h output one
// R2 - bit 7 picks direction: zero sinks, one sources
// R3 - low seven bits hold unsigned magnitude code
// R4 - magnitude zero gives no current whatever the direction bit
// R5 - current is magnitude over 127 times full scale, 127 steps
// R6 - power-up clears both settings: sink, zero magnitude
// R7 - serial clock from zero to 400 kHz, standard mode too
// R8 - answers address byte 90h for write, 91h for read
// R9 - wrong address: ignore bus until next start
// R10 - write is start, address, register, one data byte, stop
// R11 - read is start, address, one byte, nack, stop
// R12 - writes to other locations change nothing
`timescale 1ns/1ps
module dcdac_regs (
	input  wire logic       core_clk_i,        // 125 MHz core clock
	input  wire logic       rstn_i,            // async reset, active low
	input  wire logic       scl_i,             // serial clock pin
	input  wire logic       sda_i,             // serial data pin, input side
	output logic            sda_o,             // serial data output level
	output logic            sda_oe_o,          // high while pulling sda low
	output logic [7:0]      output0_setting_o, // current_output_zero setting
	output logic [7:0]      output1_setting_o, // current_output_one setting
	output logic            out0_source_o,     // output zero sources
	output logic            out0_active_o,     // output zero carries current
	output logic            current_output_one_source_o,     // output one sources
	output logic            current_output_one_active_o      // output one carries current
);
	logic [1:0] pins;
	logic       scl_s, sda_s, scl_d_r, sda_d_r;
	logic       scl_rise, scl_fall, start_det, stop_det;

	dcdac_sync #(.W(2)) u_sync (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.async_i    ({scl_i, sda_i}),
		.sync_o     (pins)
	);
	assign scl_s = pins[1];
	assign sda_s = pins[0];

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	// edge detection on the 8 ns core clock resolves 400 kHz phases easily
	assign scl_rise  = scl_s & ~scl_d_r; // R7
	assign scl_fall  = ~scl_s & scl_d_r;
	assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	dcdac_pkg::dcdac_state_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic [7:0] set0_r, set0_nxt, set1_r, set1_nxt;
	logic       drv_r, drv_nxt;
	logic       ack_pend_r, ack_pend_nxt;
	logic [7:0] rd_byte;
	logic [7:0] rx_byte;

	assign rx_byte = {shift_r[6:0], sda_s};
	// read returns the register last pointed at; unknown pointer reads zero
	always_comb begin
		unique case (ptr_r)
			dcdac_pkg::OUT0_SET_OFFSET: rd_byte = set0_r;
			dcdac_pkg::CURRENT_OUTPUT_ONE_SET_OFFSET: rd_byte = set1_r;
			default:                    rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		state_nxt    = state_r;
		shift_nxt    = shift_r;
		cnt_nxt      = cnt_r;
		ptr_nxt      = ptr_r;
		set0_nxt     = set0_r;
		set1_nxt     = set1_r;
		drv_nxt      = drv_r;
		ack_pend_nxt = ack_pend_r;
		if (start_det) begin
			state_nxt    = dcdac_pkg::ST_ADDR; // R9
			cnt_nxt      = 4'h0;
			drv_nxt      = 1'b0;
			ack_pend_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = dcdac_pkg::ST_IDLE;
			drv_nxt   = 1'b0;
		end else begin
			unique case (state_r)
				dcdac_pkg::ST_IDLE: begin
					drv_nxt = 1'b0;
				end
				dcdac_pkg::ST_ADDR, dcdac_pkg::ST_REG, dcdac_pkg::ST_DATA: begin
					if (scl_rise) begin
						shift_nxt = rx_byte;
						cnt_nxt   = cnt_r + 4'h1;
					end
					if (scl_fall && cnt_r == 4'h8) begin
						cnt_nxt = 4'h0;
						if (state_r == dcdac_pkg::ST_ADDR) begin
							if (shift_r[7:1] == dcdac_pkg::SLAVE_ADDR) begin // R8
								drv_nxt      = 1'b1;
								ack_pend_nxt = shift_r[0];
								state_nxt    = dcdac_pkg::ST_AACK;
							end else begin
								state_nxt = dcdac_pkg::ST_IDLE; // R9
							end
						end else if (state_r == dcdac_pkg::ST_REG) begin
							ptr_nxt   = shift_r;
							drv_nxt   = 1'b1;
							state_nxt = dcdac_pkg::ST_RACK;
						end else begin
							unique case (ptr_r)
								dcdac_pkg::OUT0_SET_OFFSET: set0_nxt = shift_r; // R1
								dcdac_pkg::CURRENT_OUTPUT_ONE_SET_OFFSET: set1_nxt = shift_r; // R1
								default:                    ; // R12
							endcase
							drv_nxt   = 1'b1;
							state_nxt = dcdac_pkg::ST_DACK;
						end
					end
				end
				dcdac_pkg::ST_AACK: begin
					if (scl_fall) begin
						if (ack_pend_r) begin
							shift_nxt = rd_byte;
							drv_nxt   = ~rd_byte[7];
							cnt_nxt   = 4'h0;
							state_nxt = dcdac_pkg::ST_RDAT;
						end else begin
							drv_nxt   = 1'b0;
							state_nxt = dcdac_pkg::ST_REG;
						end
					end
				end
				dcdac_pkg::ST_RACK: begin
					if (scl_fall) begin
						drv_nxt   = 1'b0;
						state_nxt = dcdac_pkg::ST_DATA;
					end
				end
				dcdac_pkg::ST_DACK: begin
					// one data byte per write; further bytes are not acknowledged
					if (scl_fall) begin
						drv_nxt   = 1'b0;
						state_nxt = dcdac_pkg::ST_IDLE; // R10
					end
				end
				dcdac_pkg::ST_RDAT: begin
					if (scl_fall) begin
						cnt_nxt = cnt_r + 4'h1;
						if (cnt_r == 4'h8) begin
							drv_nxt   = 1'b0;
							state_nxt = dcdac_pkg::ST_IDLE; // R11
						end else if (cnt_r == 4'h7) begin
							drv_nxt = 1'b0;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							drv_nxt   = ~shift_r[6];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r    <= dcdac_pkg::ST_IDLE;
			shift_r    <= 8'h00;
			cnt_r      <= 4'h0;
			ptr_r      <= 8'h00;
			set0_r     <= dcdac_pkg::SET_RESET; // R6
			set1_r     <= dcdac_pkg::SET_RESET; // R6
			drv_r      <= 1'b0;
			ack_pend_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			shift_r    <= shift_nxt;
			cnt_r      <= cnt_nxt;
			ptr_r      <= ptr_nxt;
			set0_r     <= set0_nxt;
			set1_r     <= set1_nxt;
			drv_r      <= drv_nxt;
			ack_pend_r <= ack_pend_nxt;
		end
	end

	// open drain: only ever pulls low
	assign sda_o             = 1'b0;
	assign sda_oe_o          = drv_r;
	assign output0_setting_o = set0_r;
	assign output1_setting_o = set1_r;
	// analog side scales magnitude over the 127 steps
	assign out0_source_o     = set0_r[dcdac_pkg::DIR_BIT]; // R2
	assign current_output_one_source_o     = set1_r[dcdac_pkg::DIR_BIT]; // R2
	assign out0_active_o     = |set0_r[dcdac_pkg::MAG_MSB:0]; // R3 R4 R5
	assign current_output_one_active_o     = |set1_r[dcdac_pkg::MAG_MSB:0]; // R3 R4 R5

	a_reset_clear: assert property (@(posedge core_clk_i) // R6
		$rose(rstn_i) |-> (set0_r == 8'h00 && set1_r == 8'h00))
		else $error("settings not cleared at reset");
	a_zero_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R4
		(set0_r[dcdac_pkg::MAG_MSB:0] != 7'h00 || !out0_active_o)
		&& (set1_r[dcdac_pkg::MAG_MSB:0] != 7'h00 || !current_output_one_active_o))
		else $error("zero magnitude drives current");
	a_dir_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
		current_output_one_source_o == set1_r[7] && out0_source_o == set0_r[7])
		else $error("direction mismatch");
	a_bad_addr: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
		(state_r == dcdac_pkg::ST_ADDR && scl_fall && cnt_r == 4'h8 && !start_det && !stop_det
		&& shift_r[7:1] != dcdac_pkg::SLAVE_ADDR) |=> state_r == dcdac_pkg::ST_IDLE && !sda_oe_o)
		else $error("foreign address acknowledged");
	a_good_addr: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R8
		(state_r == dcdac_pkg::ST_ADDR && scl_fall && cnt_r == 4'h8 && !start_det && !stop_det
		&& shift_r[7:1] == dcdac_pkg::SLAVE_ADDR) |=> sda_oe_o)
		else $error("own address not acknowledged");
	a_write_other: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R12
		(ptr_r != dcdac_pkg::OUT0_SET_OFFSET && ptr_r != dcdac_pkg::CURRENT_OUTPUT_ONE_SET_OFFSET
		&& state_r == dcdac_pkg::ST_DATA)
		|=> $stable(set0_r) && $stable(set1_r))
		else $error("unmapped write changed a setting");
	a_write_f8: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R1
		(state_r == dcdac_pkg::ST_DATA && ptr_r == dcdac_pkg::OUT0_SET_OFFSET
		&& scl_fall && cnt_r == 4'h8 && !start_det && !stop_det)
		|=> set0_r == $past(shift_r) && $stable(set1_r))
		else $error("write to output zero lost");
	a_write_f9: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R1
		(state_r == dcdac_pkg::ST_DATA && ptr_r == dcdac_pkg::CURRENT_OUTPUT_ONE_SET_OFFSET
		&& scl_fall && cnt_r == 4'h8 && !start_det && !stop_det)
		|=> set1_r == $past(shift_r) && $stable(set0_r))
		else $error("write to output one lost");
	a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
		state_r == dcdac_pkg::ST_IDLE |=> !sda_oe_o)
		else $error("sda driven while idle");
	c_write: cover property (@(posedge core_clk_i) state_r == dcdac_pkg::ST_DACK);
	c_read: cover property (@(posedge core_clk_i) state_r == dcdac_pkg::ST_RDAT);
	c_unmapped: cover property (@(posedge core_clk_i)
		state_r == dcdac_pkg::ST_DATA && ptr_r != dcdac_pkg::OUT0_SET_OFFSET
		&& ptr_r != dcdac_pkg::CURRENT_OUTPUT_ONE_SET_OFFSET && scl_fall && cnt_r == 4'h8);
	c_nomatch: cover property (@(posedge core_clk_i)
		state_r == dcdac_pkg::ST_ADDR ##1 state_r == dcdac_pkg::ST_IDLE);
endmodule

// File: src/dcdac_pkg.sv
// package of constants for the dual current dac control register bank
package dcdac_pkg;
	localparam logic [6:0] SLAVE_ADDR      = 7'h48;
	localparam logic [7:0] OUT0_SET_OFFSET = 8'hF8;
	localparam logic [7:0] CURRENT_OUTPUT_ONE_SET_OFFSET = 8'hF9;
	localparam logic [7:0] SET_RESET       = 8'h00;
	localparam int         DIR_BIT         = 7;
	localparam int         MAG_MSB         = 6;
	localparam int         MAG_STEPS       = 127;
	localparam int         SCL_MAX_KHZ     = 400;
	localparam int         CLK_MHZ         = 125;
	// shortest scl high or low phase the sampler must resolve, in clock cycles
	localparam int         SCL_HALF_CYC    = (CLK_MHZ * 1000) / (2 * SCL_MAX_KHZ);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b011,
		ST_REG  = 3'b010,
		ST_RACK = 3'b110,
		ST_DATA = 3'b111,
		ST_DACK = 3'b101,
		ST_RDAT = 3'b100
	} dcdac_state_t;
endpackage

// File: src/dcdac_sync.sv
// two-flop synchroniser bank for the serial pins
`timescale 1ns/1ps
module dcdac_sync #(
	parameter int W = 2
) (
	input  wire logic         core_clk_i, // core clock
	input  wire logic         rstn_i,     // async reset, active low
	input  wire logic [W-1:0] async_i,    // pins from outside
	output logic      [W-1:0] sync_o      // synchronised levels
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	// reset high: idle bus level
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_r <= '1;
			sync_r <= '1;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end
	assign sync_o = sync_r;
endmodule

// File: dv/dcdac_master.sv
// serial bus master model for the current dac register bank
`timescale 1ns/1ps
module dcdac_master (
	input  wire logic clk_i,    // core clock
	input  wire logic sda_i,    // resolved sda level
	output logic      scl_o,    // serial clock, idle high
	output logic      sda_lo_o  // high while master pulls sda low
);
	initial begin
		scl_o = 1'b1;
		sda_lo_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// data changes only in scl low, sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		sda_lo_o <= ~b;
		hold(5);
		scl_o <= 1'b1;
		hold(3);
		r = sda_i;
		hold(2);
		scl_o <= 1'b0;
	endtask
	task automatic start();
		sda_lo_o <= 1'b0;
		scl_o <= 1'b1;
		hold(5);
		sda_lo_o <= 1'b1;
		hold(5);
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		sda_lo_o <= 1'b1;
		hold(5);
		scl_o <= 1'b1;
		hold(5);
		sda_lo_o <= 1'b0;
		hold(10);
	endtask
	// msb first, ninth bit is driven as given and read back
	task automatic byte_x(input logic [7:0] d, input logic nine, output logic [7:0] q,
			output logic r9);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(nine, r9);
	endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the current dac register bank
`timescale 1ns/1ps
module tb_top;
	logic       core_clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic       scl, m_low, sda_out, sda_oe, s0, a0, s1, a1;
	logic [7:0] set0, set1;
	int         n_errors = 0;
	int         comparisons = 0;
	int         cycles = 0;
	wire logic  sda;
	// pull-up: released line reads high
	assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
	always #4 core_clk_i = ~core_clk_i;
	dcdac_master M (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_lo_o(m_low));
	dcdac_regs DUT (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_out), .sda_oe_o(sda_oe), .output0_setting_o(set0),
		.output1_setting_o(set1), .out0_source_o(s0), .out0_active_o(a0),
		.current_output_one_source_o(s1), .current_output_one_active_o(a1));
	task automatic stop_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// start, address, register, data, stop; ack low expected when addressed
	task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
			input logic acked);
		logic [7:0] q;
		logic       k;
		M.start();
		M.byte_x(a, 1'b1, q, k);
		chk("addr ack", {7'h00, ~acked}, {7'h00, k});
		M.byte_x(r, 1'b1, q, k);
		chk("reg ack", {7'h00, ~acked}, {7'h00, k});
		M.byte_x(d, 1'b1, q, k);
		chk("data ack", {7'h00, ~acked}, {7'h00, k});
		M.stop();
	endtask
	task automatic rd(input logic [7:0] exp);
		logic [7:0] q;
		logic       k;
		M.start();
		M.byte_x(8'h91, 1'b1, q, k);
		chk("read ack", 8'h00, {7'h00, k});
		M.byte_x(8'hFF, 1'b1, q, k);
		chk("read data", exp, q);
		M.stop();
	endtask
	task automatic outs(input logic [7:0] e0, input logic [7:0] e1);
		chk("setting0", e0, set0);
		chk("setting1", e1, set1);
		chk("source0", {7'h00, e0[7]}, {7'h00, s0});
		chk("active0", {7'h00, |e0[6:0]}, {7'h00, a0});
		chk("source1", {7'h00, e1[7]}, {7'h00, s1});
		chk("active1", {7'h00, |e1[6:0]}, {7'h00, a1});
	endtask
	// whole run needs about 2800 cycles; ceiling leaves wide margin
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		outs(8'h00, 8'h00);
		wr(8'h90, 8'hF8, 8'hAA, 1'b1);
		outs(8'hAA, 8'h00);
		rd(8'hAA);
		wr(8'h90, 8'hF9, 8'h80, 1'b1);
		outs(8'hAA, 8'h80);
		wr(8'h90, 8'hF9, 8'h7F, 1'b1);
		outs(8'hAA, 8'h7F);
		rd(8'h7F);
		wr(8'h90, 8'hFA, 8'h11, 1'b1);
		wr(8'h90, 8'hF7, 8'h22, 1'b1);
		outs(8'hAA, 8'h7F);
		rd(8'h00);
		wr(8'h92, 8'hF8, 8'h55, 1'b0);
		outs(8'hAA, 8'h7F);
		wr(8'h90, 8'hF8, 8'h01, 1'b1);
		outs(8'h01, 8'h7F);
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		outs(8'h00, 8'h00);
		stop_test();
	end
endmodule
